// ---- hppc_pkg.sv ----
/*
  Package for the hub port power and configuration block: register map,
  field positions, reset values and cycle counts.
  Assumes a single 20 MHz core clock and a 32-bit APB register bus.
*/
`default_nettype none
package hppc_pkg;

  localparam int NUM_PORTS = 4;

  // clock figures
  localparam longint CORE_CLK_HZ = 20000000;
  localparam longint BIT_RATE_HZ = 12000000;
  localparam int BIT_DIV_RAW = int'(CORE_CLK_HZ / BIT_RATE_HZ);
  localparam int BIT_DIV = (BIT_DIV_RAW < 1) ? 1 : BIT_DIV_RAW;

  // strap synchroniser depth and the cycle at which straps are taken
  localparam logic [1:0] STRAP_TAKE_CNT = 2'h2;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PWR_REQ = 8'h04;
  localparam logic [7:0] ADDR_OC_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_STRAPS = 8'h0C;
  localparam logic [7:0] ADDR_PORT_STAT = 8'h10;
  localparam logic [7:0] ADDR_CUSTOM_ID = 8'h14;
  localparam logic [7:0] ADDR_OC_FILTER = 8'h18;
  localparam logic [7:0] ADDR_ID_OUT = 8'h1C;

  // field positions
  localparam int CTRL_SUSPEND_BIT = 0;
  localparam int STRAP_GANG_BIT = 0;
  localparam int STRAP_CLKSEL_BIT = 1;
  localparam int STRAP_EXT_MEMORY_STRAP_N_N_BIT = 2;
  localparam int STRAP_POWER_SOURCE_STRAP_BIT = 3;
  localparam int STRAP_VALID_BIT = 4;
  localparam int STAT_POWER_LSB = 0;
  localparam int STAT_OC_LSB = 4;
  localparam int STAT_LOWSPD_LSB = 8;
  localparam int STAT_ATTACH_LSB = 12;
  localparam int STAT_UP_DP_BIT = 16;
  localparam int STAT_UP_DM_BIT = 17;
  localparam int ID_PID_LSB = 0;
  localparam int ID_VID_LSB = 16;

  // reset values
  localparam logic [15:0] OC_FILTER_RESET = 16'h0010;
  localparam logic [31:0] CUSTOM_ID_RESET = 32'h0000_0000;
  // identifiers reported without external memory; values arbitrary
  localparam logic [15:0] DEFAULT_VID = 16'h1234;
  localparam logic [15:0] DEFAULT_PID = 16'h0001;

endpackage : hppc_pkg
`default_nettype wire

// ---- hppc_oc_filter.sv ----
/*
  Overcurrent noise filter for one port: an overcurrent is accepted only
  after the (already synchronised) active-low input stays low for the
  programmed number of consecutive core clock cycles.
  Assumes the input is synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module hppc_oc_filter #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic oc_sync_n,
  input wire logic [CNT_W-1:0] filter_len,
  output logic oc_q
);
  import hppc_pkg::*;

  logic [CNT_W-1:0] low_cnt_q;

  initial
  begin
    if (CNT_W < 1 || CNT_W > 32)
      $error("hppc_oc_filter: CNT_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // a high level at once clears the count, so short spikes never qualify
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      low_cnt_q <= '0;
    else if (oc_sync_n)
      low_cnt_q <= '0;
    else if (low_cnt_q != {CNT_W{1'b1}})
      low_cnt_q <= low_cnt_q + 1'b1;
  end

  // a length of zero is served like one cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      oc_q <= 1'b0;
    else if (oc_sync_n)
      oc_q <= 1'b0;
    else if ((low_cnt_q + 1'b1) >= filter_len || low_cnt_q == {CNT_W{1'b1}})
      oc_q <= 1'b1;
  end

endmodule : hppc_oc_filter
`default_nettype wire

// ---- hppc_top.sv ----
/*
  Hub port power and configuration logic: strap capture, clock source
  control, identifier selection, downstream port power with filtered
  overcurrent, speed-dependent slew selection and an APB register file.
  Assumes straps, overcurrent inputs and USB line levels are asynchronous
  pins, and that an analog front end outside acts on the control outputs.
*/
// Decided for this implementation: the APB slave port and the register offsets.
// Overview of operation
// - grouping strap high drives all four power enables together as one group.
// - in grouped mode any overcurrent powers off every downstream port.
// - grouping strap low gives each port its own enable and overcurrent input.
// - clock-select strap low runs the core from the internal PLL output.
// - clock-select strap high takes the external fast clock, PLL off and bypassed.
// - clock-select strap high also powers down the crystal oscillator cell.
// - the core clock, not the fast clock, samples upstream data and yields a bit-rate enable.
// - memory strap high reports the default product id and leaves memory alone.
// - memory strap high disables memory clock; data pin is the grouping strap.
// - memory strap low enables the memory clock pin, held low; ids come from the custom id register.
// - power-source strap high means bus-powered, low means self-powered.
// - each downstream port picks its slew rate from the detected device speed.
// - one upstream and four downstream differential plus/minus port pairs.
// - all behaviour is fixed state machines without firmware.
// - power enables are push-pull, always driven.
// - overcurrent inputs are filtered so short spikes are ignored.
// - power enables are active low; low requests port power.
// - overcurrent inputs are active low before filtering; the filtered signal is active high.
// - active-low reset initialises all logic including power and config.
// - suspend status is high in suspend, low in normal operation.
`timescale 1ns/10ps
`default_nettype none
module hppc_top #(
  parameter int FILTER_W = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps
  input wire logic clock_select_strap,
  input wire logic ext_memory_strap_n,
  input wire logic power_source_strap,
  // shared memory pins
  input wire logic serial_mem_data_in,
  output logic serial_mem_data_out,
  output logic serial_mem_data_oe,
  output logic serial_mem_clock_out,
  output logic serial_mem_clock_oe,
  // clocking controls
  input wire logic ext_fast_clock_in,
  output logic core_clock_from_ext,
  output logic analog_pll_powerdown,
  output logic crystal_osc_powerdown,
  output logic bit_rate_en,
  // identifiers and mode
  output logic [15:0] vendor_identifier,
  output logic [15:0] product_identifier,
  output logic bus_powered,
  output logic suspend_status,
  // port power
  input wire logic [hppc_pkg::NUM_PORTS-1:0] port_overcurrent_n,
  output logic [hppc_pkg::NUM_PORTS-1:0] port_power_enable_n,
  // usb lines
  input wire logic upstream_data_plus_in,
  input wire logic upstream_data_minus_in,
  output logic upstream_data_plus_out,
  output logic upstream_data_minus_out,
  output logic upstream_data_oe,
  input wire logic [hppc_pkg::NUM_PORTS-1:0] downstream_data_plus_in,
  input wire logic [hppc_pkg::NUM_PORTS-1:0] downstream_data_minus_in,
  output logic [hppc_pkg::NUM_PORTS-1:0] downstream_data_plus_out,
  output logic [hppc_pkg::NUM_PORTS-1:0] downstream_data_minus_out,
  output logic [hppc_pkg::NUM_PORTS-1:0] downstream_data_oe,
  output logic [hppc_pkg::NUM_PORTS-1:0] downstream_slew_low
);
  import hppc_pkg::*;

  initial
  begin
    if (FILTER_W < 1 || FILTER_W > 16)
      $error("hppc_top: FILTER_W must be 1..16");
  end

  typedef enum logic [1:0] {
    HPPC_CFG_WAIT,
    HPPC_CFG_TAKE,
    HPPC_CFG_RUN
  } hppc_cfg_t;

  hppc_cfg_t cfg_state_q;
  logic [1:0] take_cnt_q;
  logic [4:0] strap_s1_q;
  logic [4:0] strap_s2_q;
  logic gang_q;
  logic clk_sel_q;
  logic ext_mem_n_q;
  logic bus_pwr_q;
  logic cfg_valid_q;
  logic suspend_q;
  logic [NUM_PORTS-1:0] pwr_req_q;
  logic [NUM_PORTS-1:0] oc_flag_q;
  logic [NUM_PORTS-1:0] oc_s1_q;
  logic [NUM_PORTS-1:0] oc_s2_q;
  logic [NUM_PORTS-1:0] oc_filt;
  logic [NUM_PORTS-1:0] dp_s1_q;
  logic [NUM_PORTS-1:0] dp_s2_q;
  logic [NUM_PORTS-1:0] dm_s1_q;
  logic [NUM_PORTS-1:0] dm_s2_q;
  logic [NUM_PORTS-1:0] low_speed_q;
  logic [NUM_PORTS-1:0] attached_q;
  logic [1:0] up_s1_q;
  logic [1:0] up_s2_q;
  logic [1:0] up_sample_q;
  logic [31:0] custom_id_q;
  logic [15:0] filter_len_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] bit_cnt_q;
  logic any_oc;
  logic oc_trip;
  logic [NUM_PORTS-1:0] oc_cut;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture: two-stage synchronisers, then a one-time latch
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
    end
    else
    begin
      strap_s1_q <= {ext_fast_clock_in, power_source_strap, ext_memory_strap_n,
                     clock_select_strap, serial_mem_data_in};
      strap_s2_q <= strap_s1_q;
    end
  end

  // the synchroniser needs two edges before its output is trustworthy
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_state_q <= HPPC_CFG_WAIT;
      take_cnt_q <= '0;
    end
    else
    begin
      case (cfg_state_q)
        HPPC_CFG_WAIT:
        begin
          take_cnt_q <= take_cnt_q + 2'h1;
          if (take_cnt_q == STRAP_TAKE_CNT - 2'h1)
            cfg_state_q <= HPPC_CFG_TAKE;
        end
        HPPC_CFG_TAKE:
          cfg_state_q <= HPPC_CFG_RUN;
        HPPC_CFG_RUN:
          cfg_state_q <= HPPC_CFG_RUN;
        default:
          cfg_state_q <= HPPC_CFG_WAIT;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gang_q <= 1'b0;
      clk_sel_q <= 1'b0;
      ext_mem_n_q <= 1'b1;
      bus_pwr_q <= 1'b0;
      cfg_valid_q <= 1'b0;
    end
    else if (cfg_state_q == HPPC_CFG_TAKE)
    begin
      // grouping strap is only a strap when memory is disabled
      gang_q <= strap_s2_q[STRAP_EXT_MEMORY_STRAP_N_N_BIT] & strap_s2_q[STRAP_GANG_BIT];
      clk_sel_q <= strap_s2_q[STRAP_CLKSEL_BIT];
      ext_mem_n_q <= strap_s2_q[STRAP_EXT_MEMORY_STRAP_N_N_BIT];
      bus_pwr_q <= strap_s2_q[STRAP_POWER_SOURCE_STRAP_BIT];
      cfg_valid_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source control; the mux itself is analog and sits outside
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_clock_from_ext <= 1'b0;
      analog_pll_powerdown <= 1'b0;
      crystal_osc_powerdown <= 1'b0;
    end
    else
    begin
      core_clock_from_ext <= clk_sel_q;
      analog_pll_powerdown <= clk_sel_q;
      crystal_osc_powerdown <= clk_sel_q;
    end
  end

  // bit-rate enable from the core clock; limited by the core clock rate
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_cnt_q <= '0;
      bit_rate_en <= 1'b0;
    end
    else if (bit_cnt_q == 8'(BIT_DIV - 1))
    begin
      bit_cnt_q <= '0;
      bit_rate_en <= 1'b1;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 8'h01;
      bit_rate_en <= 1'b0;
    end
  end

  // upstream lines sampled on the bit-rate enable
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      up_s1_q <= '0;
      up_s2_q <= '0;
      up_sample_q <= '0;
    end
    else
    begin
      up_s1_q <= {upstream_data_minus_in, upstream_data_plus_in};
      up_s2_q <= up_s1_q;
      if (bit_rate_en)
        up_sample_q <= up_s2_q;
    end
  end

  // line drivers stay released; packet handling lives elsewhere
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      upstream_data_plus_out <= 1'b0;
      upstream_data_minus_out <= 1'b0;
      upstream_data_oe <= 1'b0;
      downstream_data_plus_out <= '0;
      downstream_data_minus_out <= '0;
      downstream_data_oe <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // identifiers, power mode and shared memory pins
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vendor_identifier <= DEFAULT_VID;
      product_identifier <= DEFAULT_PID;
      bus_powered <= 1'b0;
      serial_mem_clock_oe <= 1'b0;
      serial_mem_clock_out <= 1'b0;
      serial_mem_data_out <= 1'b0;
      serial_mem_data_oe <= 1'b0;
    end
    else
    begin
      bus_powered <= bus_pwr_q;
      serial_mem_data_out <= 1'b0;
      serial_mem_data_oe <= 1'b0;
      serial_mem_clock_out <= 1'b0;
      if (ext_mem_n_q)
      begin
        vendor_identifier <= DEFAULT_VID;
        product_identifier <= DEFAULT_PID;
        serial_mem_clock_oe <= 1'b0;
      end
      else
      begin
        vendor_identifier <= custom_id_q[ID_VID_LSB +: 16];
        product_identifier <= custom_id_q[ID_PID_LSB +: 16];
        serial_mem_clock_oe <= cfg_valid_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overcurrent synchronise and filter, speed detect, per port
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++)
    begin : g_port
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          oc_s1_q[gi] <= 1'b1;
          oc_s2_q[gi] <= 1'b1;
          dp_s1_q[gi] <= 1'b0;
          dp_s2_q[gi] <= 1'b0;
          dm_s1_q[gi] <= 1'b0;
          dm_s2_q[gi] <= 1'b0;
        end
        else
        begin
          oc_s1_q[gi] <= port_overcurrent_n[gi];
          oc_s2_q[gi] <= oc_s1_q[gi];
          dp_s1_q[gi] <= downstream_data_plus_in[gi];
          dp_s2_q[gi] <= dp_s1_q[gi];
          dm_s1_q[gi] <= downstream_data_minus_in[gi];
          dm_s2_q[gi] <= dm_s1_q[gi];
        end
      end

      hppc_oc_filter #(
        .CNT_W(FILTER_W)
      ) u_filter (
        .core_clk(core_clk),
        .nrst(nrst),
        .oc_sync_n(oc_s2_q[gi]),
        .filter_len(filter_len_q[FILTER_W-1:0]),
        .oc_q(oc_filt[gi])
      );

      // idle j-state tells the speed: d- high is low speed
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          low_speed_q[gi] <= 1'b0;
          attached_q[gi] <= 1'b0;
        end
        else if (dm_s2_q[gi] && !dp_s2_q[gi])
        begin
          low_speed_q[gi] <= 1'b1;
          attached_q[gi] <= 1'b1;
        end
        else if (dp_s2_q[gi] && !dm_s2_q[gi])
        begin
          low_speed_q[gi] <= 1'b0;
          attached_q[gi] <= 1'b1;
        end
        else if (!dp_s2_q[gi] && !dm_s2_q[gi])
          attached_q[gi] <= 1'b0;
      end
    end
  endgenerate

  assign downstream_slew_low = low_speed_q;

  ////////////////////////////////////////////////////////////////////////////
  // port power: hardware cut on overcurrent beats a software request
  assign any_oc = |oc_filt;
  assign oc_trip = gang_q && any_oc;
  assign oc_cut = oc_trip ? {NUM_PORTS{1'b1}} : oc_filt;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pwr_req_q <= '0;
    else if (wr_en && paddr == ADDR_PWR_REQ)
      pwr_req_q <= gang_q ? {NUM_PORTS{pwdata[0]}} & ~oc_cut
                          : pwdata[NUM_PORTS-1:0] & ~oc_cut;
    else
      pwr_req_q <= pwr_req_q & ~oc_cut;
  end

  // push-pull active-low enables, driven from reset on
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      port_power_enable_n <= {NUM_PORTS{1'b1}};
    else
      port_power_enable_n <= ~pwr_req_q;
  end

  // sticky overcurrent flags, write one to clear; a new event wins
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      oc_flag_q <= '0;
    else if (wr_en && paddr == ADDR_OC_FLAGS)
      oc_flag_q <= (oc_flag_q & ~pwdata[NUM_PORTS-1:0]) | oc_filt;
    else
      oc_flag_q <= oc_flag_q | oc_filt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      suspend_q <= 1'b0;
      custom_id_q <= CUSTOM_ID_RESET;
      filter_len_q <= OC_FILTER_RESET;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADDR_CTRL:
          suspend_q <= pwdata[CTRL_SUSPEND_BIT];
        ADDR_CUSTOM_ID:
          custom_id_q <= pwdata;
        ADDR_OC_FILTER:
          filter_len_q <= pwdata[15:0];
        default:
          suspend_q <= suspend_q;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      suspend_status <= 1'b0;
    else
      suspend_status <= suspend_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read path: data captured in setup, answered in the access phase
  always_comb
  begin
    addr_ok = 1'b1;
    rdata_d = '0;
    case (paddr)
      ADDR_CTRL:
        rdata_d[CTRL_SUSPEND_BIT] = suspend_q;
      ADDR_PWR_REQ:
        rdata_d[NUM_PORTS-1:0] = pwr_req_q;
      ADDR_OC_FLAGS:
        rdata_d[NUM_PORTS-1:0] = oc_flag_q;
      ADDR_STRAPS:
        rdata_d[STRAP_VALID_BIT:0] = {cfg_valid_q, bus_pwr_q, ext_mem_n_q,
                                      clk_sel_q, gang_q};
      ADDR_PORT_STAT:
      begin
        rdata_d[STAT_POWER_LSB +: NUM_PORTS] = ~port_power_enable_n;
        rdata_d[STAT_OC_LSB +: NUM_PORTS] = oc_filt;
        rdata_d[STAT_LOWSPD_LSB +: NUM_PORTS] = low_speed_q;
        rdata_d[STAT_ATTACH_LSB +: NUM_PORTS] = attached_q;
        rdata_d[STAT_UP_DP_BIT] = up_sample_q[0];
        rdata_d[STAT_UP_DM_BIT] = up_sample_q[1];
      end
      ADDR_CUSTOM_ID:
        rdata_d = custom_id_q;
      ADDR_OC_FILTER:
        rdata_d[15:0] = filter_len_q;
      ADDR_ID_OUT:
        rdata_d = {vendor_identifier, product_identifier};
      default:
        addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= '0;
    else if (rd_setup)
      rdata_q <= rdata_d;
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

endmodule : hppc_top
`default_nettype wire

// ---- hppc_power_switch_model.sv ----
/*
  External port power switch model for the hub port power block.
  Assumes fault_req is driven by the bench just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module hppc_power_switch_model (
  input wire logic [hppc_pkg::NUM_PORTS-1:0] port_power_enable_n,
  input wire logic [hppc_pkg::NUM_PORTS-1:0] fault_req,
  output logic [hppc_pkg::NUM_PORTS-1:0] port_overcurrent_n
);
  import hppc_pkg::*;
  // a switch only trips on a port it powers; the flag line is pulled up otherwise
  assign port_overcurrent_n = ~(fault_req & ~port_power_enable_n);
endmodule : hppc_power_switch_model
`default_nettype wire

// ---- hppc_top_asserts.sv ----
/*
  Concurrent checks on the ports of the hub port power block.
  Assumes straps only change while nrst is low, except the clock select pin.
*/
`timescale 1ns/10ps
`default_nettype none
module hppc_top_asserts (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic clock_select_strap,
  input wire logic ext_memory_strap_n,
  input wire logic serial_mem_data_in,
  input wire logic serial_mem_clock_oe,
  input wire logic core_clock_from_ext,
  input wire logic analog_pll_powerdown,
  input wire logic crystal_osc_powerdown,
  input wire logic [15:0] vendor_identifier,
  input wire logic [15:0] product_identifier,
  input wire logic suspend_status,
  input wire logic [hppc_pkg::NUM_PORTS-1:0] port_overcurrent_n,
  input wire logic [hppc_pkg::NUM_PORTS-1:0] port_power_enable_n
);
  import hppc_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  logic [3:0] age_q;
  logic [2:0] strap_q;
  wire logic settled = (age_q > 4'h6);
  wire logic wr_pwr = psel && penable && pwrite && (paddr == ADDR_PWR_REQ);
  ////////////////////////////////////////////////////////////////////////
  // pins copied on the first edge after release; later pin changes must not matter
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
      age_q <= 4'h0;
    else if (age_q != 4'hF)
      age_q <= age_q + 4'h1;
  always_ff @(posedge core_clk)
    if (nrst && age_q == 4'h0)
      strap_q <= {clock_select_strap, ext_memory_strap_n, serial_mem_data_in};
  rst_state_a: assert property ($rose(nrst) |-> port_power_enable_n == 4'hF && !suspend_status)
    else $error("power or suspend not in reset state");
  suspend_follow_a: assert property (psel && penable && pwrite && paddr == ADDR_CTRL
    |-> ##2 suspend_status == $past(pwdata[0], 2))
    else $error("suspend status does not follow control write");
  power_on_a: assert property (|(~port_power_enable_n & $past(port_power_enable_n)) |-> $past(wr_pwr, 2))
    else $error("port powered without a power request write");
  power_off_a: assert property (|(port_power_enable_n & ~$past(port_power_enable_n))
    |-> $past(wr_pwr, 2) || $past(port_overcurrent_n, 3) != 4'hF)
    else $error("port powered off with no cause");
  group_a: assert property (settled && strap_q[1] && strap_q[0]
    |-> port_power_enable_n == 4'h0 || port_power_enable_n == 4'hF)
    else $error("grouped enables differ");
  clk_src_a: assert property (settled
    |-> core_clock_from_ext == strap_q[2] && analog_pll_powerdown == strap_q[2]
    && crystal_osc_powerdown == strap_q[2])
    else $error("clock source controls disagree with strap");
  default_id_a: assert property (settled && strap_q[1]
    |-> vendor_identifier == DEFAULT_VID && product_identifier == DEFAULT_PID)
    else $error("default identifiers not reported");
  mem_clock_a: assert property (settled |-> serial_mem_clock_oe == !strap_q[1])
    else $error("memory clock enable disagrees with strap");
  cover property (settled && port_power_enable_n == 4'h0);
  cover property (settled && port_power_enable_n == 4'h2);
  cover property ($rose(suspend_status));
endmodule : hppc_top_asserts
bind hppc_top hppc_top_asserts hppc_top_asserts_inst (.*);
`default_nettype wire

// ---- hppc_top_tb.sv ----
/*
  Self-checking bench for the hub port power block with a switch model.
  Assumes zero to 19 APB wait states and a 20 MHz core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hppc_top_tb;
  import hppc_pkg::*;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic clock_select_strap = 1'h0, ext_memory_strap_n = 1'h1, power_source_strap = 1'h0;
  logic serial_mem_data_in = 1'h0, ext_fast_clock_in = 1'h0, serial_mem_clock_oe;
  logic upstream_data_plus_in = 1'h1, upstream_data_minus_in = 1'h0;
  logic [3:0] downstream_data_plus_in = 4'h0, downstream_data_minus_in = 4'h0, fault = 4'h0;
  logic [3:0] port_overcurrent_n, port_power_enable_n, downstream_slew_low;
  logic core_clock_from_ext, analog_pll_powerdown, crystal_osc_powerdown;
  logic bus_powered, suspend_status;
  logic [15:0] vendor_identifier, product_identifier;
  int err_count = 0, num_checks = 0;
  hppc_top hppc_top_inst (.*, .serial_mem_data_out(), .serial_mem_data_oe(),
    .serial_mem_clock_out(), .bit_rate_en(), .upstream_data_plus_out(),
    .upstream_data_minus_out(), .upstream_data_oe(), .downstream_data_plus_out(),
    .downstream_data_minus_out(), .downstream_data_oe());
  hppc_power_switch_model hppc_power_switch_model_inst (.port_power_enable_n(port_power_enable_n),
    .fault_req(fault), .port_overcurrent_n(port_overcurrent_n));
  always #25 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge core_clk);
      if (pready === 1'h1)
        break;
    end
    chk("apb ready", 32'h0, 32'(n == 20));
    if (n == 20)
      conclude();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // straps change only inside reset; only the clock select pin is later moved in operation
  task automatic rst(input logic [3:0] s);
    @(posedge core_clk);
    nrst <= 1'h0;
    {power_source_strap, ext_memory_strap_n, clock_select_strap, serial_mem_data_in} <= s;
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (8) @(posedge core_clk);
  endtask : rst
  task automatic wait_pen(input logic [3:0] exp);
    int n;
    for (n = 0; n < 40 && port_power_enable_n !== exp; n++)
      @(posedge core_clk);
    chk("port power", 32'(exp), 32'(port_power_enable_n));
    if (port_power_enable_n !== exp)
      conclude();
  endtask : wait_pen
  ////////////////////////////////////////////////////////////////////////
  task automatic t_cfg(input logic [3:0] s);
    logic [31:0] st;
    logic [31:0] id;
    st = {27'h0, 1'h1, s[3:1], s[0] & s[2]};
    id = s[2] ? {DEFAULT_VID, DEFAULT_PID} : 32'hA5C3_0F96;
    rst(s);
    apb(1'h1, ADDR_CUSTOM_ID, 32'hA5C3_0F96);
    apb(1'h0, ADDR_STRAPS, 32'h0);
    clock_select_strap <= ~s[1];
    chk("straps", st, rd);
    chk("clock ctl", 32'({3{s[1]}}), 32'({core_clock_from_ext, analog_pll_powerdown, crystal_osc_powerdown}));
    chk("power source", 32'(s[3]), 32'(bus_powered));
    chk("mem clock oe", 32'(!s[2]), 32'(serial_mem_clock_oe));
    repeat (4) @(posedge core_clk);
    apb(1'h0, ADDR_ID_OUT, 32'h0);
    chk("id outputs", id, {vendor_identifier, product_identifier});
    chk("id register", id, rd);
    apb(1'h0, ADDR_STRAPS, 32'h0);
    chk("straps held", st, rd);
    chk("clock held", 32'(s[1]), 32'(core_clock_from_ext));
    $display("config test done");
  endtask : t_cfg
  task automatic t_gang();
    rst(4'h5);
    apb(1'h1, ADDR_OC_FILTER, 32'h3);
    apb(1'h1, ADDR_PWR_REQ, 32'h1);
    wait_pen(4'h0);
    fault <= 4'h4;
    repeat (2) @(posedge core_clk);
    fault <= 4'h0;
    repeat (10) @(posedge core_clk);
    chk("spike ignored", 32'h0, 32'(port_power_enable_n));
    fault <= 4'h4;
    wait_pen(4'hF);
    fault <= 4'h0;
    apb(1'h0, ADDR_OC_FLAGS, 32'h0);
    chk("oc flags", 32'h4, rd);
    $display("grouped test done");
  endtask : t_gang
  task automatic t_port();
    rst(4'h4);
    apb(1'h1, ADDR_OC_FILTER, 32'h2);
    apb(1'h1, ADDR_PWR_REQ, 32'hF);
    wait_pen(4'h0);
    fault <= 4'h2;
    wait_pen(4'h2);
    fault <= 4'h0;
    repeat (6) @(posedge core_clk);
    apb(1'h1, ADDR_PWR_REQ, 32'hF);
    wait_pen(4'h0);
    rst(4'h4);
    chk("power after reset", 32'hF, 32'(port_power_enable_n));
    $display("per port test done");
  endtask : t_port
  task automatic t_misc();
    int n;
    apb(1'h1, ADDR_CTRL, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("suspend on", 32'h1, 32'(suspend_status));
    apb(1'h1, ADDR_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("suspend off", 32'h0, 32'(suspend_status));
    downstream_data_plus_in <= 4'hE;
    downstream_data_minus_in <= 4'h1;
    for (n = 0; n < 40 && downstream_slew_low !== 4'h1; n++)
      @(posedge core_clk);
    chk("slew select", 32'h1, 32'(downstream_slew_low));
    if (downstream_slew_low !== 4'h1)
      conclude();
    apb(1'h0, ADDR_PORT_STAT, 32'h0);
    chk("port status", 32'h0001_F100, rd);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, 32'(er));
    chk("unmapped data", 32'h0, rd);
    $display("misc test done");
  endtask : t_misc
  initial
  begin
    t_cfg(4'hE);
    t_cfg(4'h1);
    t_gang();
    t_port();
    t_misc();
    conclude();
  end
endmodule : hppc_top_tb
`default_nettype wire
